// ==== verilog/sfdpr_map.svh ====
// Constant map of the discoverable-parameter ROM block.
// Assumes a 32-bit AHB-Lite bus with word-aligned register offsets.
`ifndef SFDPR_MAP_SVH
`define SFDPR_MAP_SVH

// Register byte offsets
`define SFDPR_OFS_PTR 32'h0000_0000
`define SFDPR_OFS_DATA 32'h0000_0004
`define SFDPR_OFS_CTRL 32'h0000_0008

// Reset values
`define SFDPR_RST_PTR 24'h00_0000
`define SFDPR_RST_DENS 1'h0
`define SFDPR_CTRL_DENS_BIT 0

// Header pointer bytes and table base in parameter space
`define SFDPR_HDR_PTR0 24'h00_0014
`define SFDPR_HDR_PTR1 24'h00_0015
`define SFDPR_HDR_PTR2 24'h00_0016
`define SFDPR_HDR_IDMSB 24'h00_0017
`define SFDPR_TBL_BASE 24'h00_0340

// Byte contents
`define SFDPR_V_PTR0 8'h40
`define SFDPR_V_PTR1 8'h03
`define SFDPR_V_PTR2 8'h00
`define SFDPR_V_IDMSB 8'hFF
`define SFDPR_V_CAPS 8'hE5
`define SFDPR_V_ERASE4K 8'h20
`define SFDPR_V_RDMODES 8'hFB
`define SFDPR_V_UNUSED 8'hFF
`define SFDPR_V_DENS_LO 8'hFF
`define SFDPR_V_DENS128 8'h07
`define SFDPR_V_DENS256 8'h0F
`define SFDPR_V_QIO_CYC 8'h48
`define SFDPR_V_QIO_OP 8'hEB
`define SFDPR_V_QOR_CYC 8'h08
`define SFDPR_V_QOR_OP 8'h6B
`define SFDPR_V_FILL 8'hFF

// AHB encodings
`define SFDPR_HTRANS_NONSEQ 2'h2
`define SFDPR_HTRANS_SEQ 2'h3

`endif

// ==== verilog/sfdpr_pkg.sv ====
// Types shared by the discoverable-parameter ROM block.
// Assumes the constant map header is compiled alongside.
`default_nettype none
package sfdpr_pkg;

    // Bus phase tracker, one-hot
    typedef enum logic [1:0] {
        SFDPR_IDLE = 2'h1,
        SFDPR_WDATA = 2'h2
    } sfdpr_phase_type;

    // Register selected by a pending write
    typedef enum logic [1:0] {
        SFDPR_SEL_NONE = 2'h0,
        SFDPR_SEL_PTR = 2'h1,
        SFDPR_SEL_CTRL = 2'h2
    } sfdpr_sel_type;

    // Whole state of the slave
    typedef struct packed {
        sfdpr_phase_type phase;
        sfdpr_sel_type wsel;
        logic [23:0] ptr;
        logic dens;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } sfdpr_state_type;

endpackage : sfdpr_pkg
`default_nettype wire

// ==== verilog/sfdpr_rom.sv ====
// AHB-Lite slave that serves the discoverable-parameter byte space.
// Assumes a single AHB-Lite master, word transfers, one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "sfdpr_map.svh"

module sfdpr_rom (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O
);

    // Registered state and its next value
    sfdpr_pkg::sfdpr_state_type st;
    sfdpr_pkg::sfdpr_state_type next_st;

    // Address phase qualifiers
    logic acc; // Valid transfer taken this edge
    logic [31:0] wadr; // Word-aligned address
    logic rd_data; // Read of the streaming data port
    logic [23:0] eff_ptr; // Pointer with a pending write folded in
    logic eff_dens; // Density select with pending write folded in

    // Byte lookup; unlisted addresses read the erased fill value
    function automatic logic [7:0] rom_byte(input logic [23:0] a,
                                            input logic dens);
        logic [7:0] v;
        v = `SFDPR_V_FILL;
        case (a)
            `SFDPR_HDR_PTR0: v = `SFDPR_V_PTR0;
            `SFDPR_HDR_PTR1: v = `SFDPR_V_PTR1;
            `SFDPR_HDR_PTR2: v = `SFDPR_V_PTR2;
            `SFDPR_HDR_IDMSB: v = `SFDPR_V_IDMSB;
            `SFDPR_TBL_BASE + 24'h0: v = `SFDPR_V_CAPS;
            `SFDPR_TBL_BASE + 24'h1: v = `SFDPR_V_ERASE4K;
            `SFDPR_TBL_BASE + 24'h2: v = `SFDPR_V_RDMODES;
            `SFDPR_TBL_BASE + 24'h3: v = `SFDPR_V_UNUSED;
            `SFDPR_TBL_BASE + 24'h4,
            `SFDPR_TBL_BASE + 24'h5,
            `SFDPR_TBL_BASE + 24'h6: v = `SFDPR_V_DENS_LO;
            `SFDPR_TBL_BASE + 24'h7: begin
                // Only the top density byte depends on the part size
                v = dens ? `SFDPR_V_DENS256 : `SFDPR_V_DENS128;
            end
            `SFDPR_TBL_BASE + 24'h8: v = `SFDPR_V_QIO_CYC;
            `SFDPR_TBL_BASE + 24'h9: v = `SFDPR_V_QIO_OP;
            `SFDPR_TBL_BASE + 24'hA: v = `SFDPR_V_QOR_CYC;
            `SFDPR_TBL_BASE + 24'hB: v = `SFDPR_V_QOR_OP;
            default: v = `SFDPR_V_FILL;
        endcase
        return v;
    endfunction : rom_byte

    // Decode of the address phase
    assign acc = HSEL_I && HREADY_I && (HTRANS_I == `SFDPR_HTRANS_NONSEQ
                 || HTRANS_I == `SFDPR_HTRANS_SEQ);
    assign wadr = {HADDR_I[31:2], 2'h0};
    assign rd_data = acc && !HWRITE_I && (wadr == `SFDPR_OFS_DATA);

    // A write data phase overlaps the next address phase, so a pointer
    // written just before a data read must already steer that read
    always_comb begin
        eff_ptr = st.ptr;
        eff_dens = st.dens;
        if (st.phase == sfdpr_pkg::SFDPR_WDATA) begin
            if (st.wsel == sfdpr_pkg::SFDPR_SEL_PTR) begin
                eff_ptr = HWDATA_I[23:0];
            end
            if (st.wsel == sfdpr_pkg::SFDPR_SEL_CTRL) begin
                eff_dens = HWDATA_I[`SFDPR_CTRL_DENS_BIT];
            end
        end
    end

    // Next-state logic: always zero wait states, always OKAY
    always_comb begin
        next_st = st;
        next_st.ptr = eff_ptr;
        next_st.dens = eff_dens;
        next_st.ready = 1'b1;
        next_st.resp = 1'b0;
        next_st.phase = sfdpr_pkg::SFDPR_IDLE;
        next_st.wsel = sfdpr_pkg::SFDPR_SEL_NONE;
        if (acc && HWRITE_I) begin
            // Remember the target; data arrives next cycle
            next_st.phase = sfdpr_pkg::SFDPR_WDATA;
            case (wadr)
                `SFDPR_OFS_PTR: next_st.wsel = sfdpr_pkg::SFDPR_SEL_PTR;
                `SFDPR_OFS_CTRL: next_st.wsel = sfdpr_pkg::SFDPR_SEL_CTRL;
                default: next_st.wsel = sfdpr_pkg::SFDPR_SEL_NONE;
            endcase
        end else if (acc) begin
            // Reads are answered in the data phase from this register
            case (wadr)
                `SFDPR_OFS_PTR: next_st.rdata = {8'h00, eff_ptr};
                `SFDPR_OFS_DATA: begin
                    next_st.rdata = {24'h00_0000, rom_byte(eff_ptr,
                                                         eff_dens)};
                    next_st.ptr = eff_ptr + 24'h1;
                end
                `SFDPR_OFS_CTRL: next_st.rdata = {31'h0, eff_dens};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st.phase <= sfdpr_pkg::SFDPR_IDLE;
            st.wsel <= sfdpr_pkg::SFDPR_SEL_NONE;
            st.ptr <= `SFDPR_RST_PTR;
            st.dens <= `SFDPR_RST_DENS;
            st.rdata <= 32'h0000_0000;
            st.ready <= 1'b1;
            st.resp <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register
    assign HRDATA_O = st.rdata;
    assign HREADYOUT_O = st.ready;
    assign HRESP_O = st.resp;

    // Checks on the served bytes, keyed on the pointer at the read.
    // Each byte check fires on the edge that takes a data-port read and looks
    // one edge later, in the data phase where the master takes the byte.
    // Expected bytes are written as literals on purpose, so a slip in
    // the constant map shows up here instead of being copied.
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    // Header pointer byte 0, and the slave still ready one cycle on
    a_hdr_ptr_lo: assert property (
        rd_data && eff_ptr == `SFDPR_HDR_PTR0
        |=> HRDATA_O == 32'h0000_0040 ##1 HREADYOUT_O)
        else $error("header pointer byte 0 wrong");

    // Header pointer byte 1, with nothing leaking into the upper lanes
    a_hdr_ptr_hi: assert property (
        rd_data && eff_ptr == `SFDPR_HDR_PTR1
        |=> HRDATA_O[7:0] == 8'h03 && HRDATA_O[31:8] == 24'h0)
        else $error("header pointer byte 1 wrong");

    // Header pointer byte 2 is zero, so the table sits below 64 KB
    a_hdr_ptr_top: assert property (
        rd_data && eff_ptr == `SFDPR_HDR_PTR2
        |=> HRDATA_O == 32'h0000_0000)
        else $error("header pointer byte 2 wrong");

    // Identifier byte that marks a standard-defined parameter
    a_hdr_id_msb: assert property (
        rd_data && eff_ptr == `SFDPR_HDR_IDMSB
        |=> HRDATA_O == 32'h0000_00FF)
        else $error("header id byte wrong");

    // Capability byte: erase granularity, buffer size, status write
    a_tbl_caps: assert property (
        rd_data && eff_ptr == 24'h00_0340 |=> HRDATA_O[7:0] == 8'hE5)
        else $error("capability byte wrong");

    // Opcode the host must use for the small uniform erase
    a_tbl_erase_op: assert property (
        rd_data && eff_ptr == 24'h00_0341 |=> HRDATA_O[7:0] == 8'h20)
        else $error("erase opcode byte wrong");

    // Supported read modes and the address-byte option
    a_tbl_rd_modes: assert property (
        rd_data && eff_ptr == 24'h00_0342 |=> HRDATA_O[7:0] == 8'hFB)
        else $error("read modes byte wrong");

    // Unused top byte of the first parameter word reads all ones
    a_tbl_unused: assert property (
        rd_data && eff_ptr == 24'h00_0343 |=> HRDATA_O[7:0] == 8'hFF)
        else $error("unused byte wrong");

    // Lower three density bytes are the same for both part sizes
    a_tbl_dens_low: assert property (
        rd_data && eff_ptr >= 24'h00_0344 && eff_ptr <= 24'h00_0346
        |=> HRDATA_O[7:0] == 8'hFF)
        else $error("density low byte wrong");

    // Top density byte follows the size select seen at the read
    a_tbl_density: assert property (
        rd_data && eff_ptr == 24'h00_0347
        |=> HRDATA_O[7:0] == ($past(eff_dens) ? 8'h0F : 8'h07))
        else $error("density top byte wrong");

    // A size select write must land in the select register
    a_dens_write: assert property (
        st.phase == sfdpr_pkg::SFDPR_WDATA
        && st.wsel == sfdpr_pkg::SFDPR_SEL_CTRL
        |=> st.dens == $past(HWDATA_I[`SFDPR_CTRL_DENS_BIT]))
        else $error("density select write lost");

    // Mode and dummy counts of the quad input/output read
    a_tbl_quad_io_cyc: assert property (
        rd_data && eff_ptr == 24'h00_0348 |=> HRDATA_O[7:0] == 8'h48)
        else $error("quad io cycle byte wrong");

    // Opcode of the quad input/output read
    a_tbl_quad_io_op: assert property (
        rd_data && eff_ptr == 24'h00_0349 |=> HRDATA_O[7:0] == 8'hEB)
        else $error("quad io opcode byte wrong");

    // Count and opcode pair read back to back keeps its order
    a_tbl_quad_io: assert property (
        rd_data && eff_ptr == 24'h00_0348 ##1 rd_data
        |=> HRDATA_O[7:0] == 8'hEB && $past(HRDATA_O[7:0]) == 8'h48)
        else $error("quad io pair wrong");

    // Mode and dummy counts of the quad-output read
    a_tbl_quad_out_cyc: assert property (
        rd_data && eff_ptr == 24'h00_034A |=> HRDATA_O[7:0] == 8'h08)
        else $error("quad output cycle byte wrong");

    // Opcode of the quad-output read
    a_tbl_quad_out_op: assert property (
        rd_data && eff_ptr == 24'h00_034B |=> HRDATA_O[7:0] == 8'h6B)
        else $error("quad output opcode byte wrong");

    // Count and opcode pair of the quad-output read, back to back
    a_tbl_quad_out: assert property (
        rd_data && eff_ptr == 24'h00_034A ##1 rd_data
        |=> HRDATA_O[7:0] == 8'h6B && $past(HRDATA_O[7:0]) == 8'h08)
        else $error("quad output pair wrong");

    // Past the visible table the erased fill value comes back
    a_tbl_fill: assert property (
        rd_data && eff_ptr == 24'h00_034C |=> HRDATA_O == 32'h0000_00FF)
        else $error("fill byte wrong");

    // Each data-port read hands over exactly one byte in the low lane
    a_data_one_byte: assert property (
        rd_data |=> HRDATA_O[31:8] == 24'h00_0000)
        else $error("data read upper lanes not zero");

    // Each data-port read moves the pointer on by exactly one byte
    a_ptr_advance: assert property (
        rd_data |=> st.ptr == $past(eff_ptr) + 24'h1)
        else $error("pointer did not advance");

    // A pointer write with no read on top must set the start address
    a_ptr_write: assert property (
        st.phase == sfdpr_pkg::SFDPR_WDATA
        && st.wsel == sfdpr_pkg::SFDPR_SEL_PTR && !rd_data
        |=> st.ptr == $past(HWDATA_I[23:0]))
        else $error("pointer write lost");

    // Without a read or a pointer write the address must not drift
    a_ptr_hold: assert property (
        !rd_data && st.phase != sfdpr_pkg::SFDPR_WDATA |=> $stable(st.ptr))
        else $error("pointer moved on its own");

    // Reading the pointer register shows the address of the next byte
    a_ptr_readback: assert property (
        acc && !HWRITE_I && wadr == `SFDPR_OFS_PTR
        |=> HRDATA_O == {8'h00, $past(eff_ptr)})
        else $error("pointer readback wrong");

    // The slave never stalls and never answers with an error
    a_bus_okay: assert property (
        HREADYOUT_O && !HRESP_O)
        else $error("slave stalled or erred");

endmodule : sfdpr_rom
`default_nettype wire

// ==== test/sfdpr_host.sv ====
// Bus master model that stands in for the host reading parameters.
// Assumes one zero-or-more wait state slave whose hreadyout is hready.
`timescale 1ns/100ps
`default_nettype none

module sfdpr_host (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [31:0] hwdata_o
);
    // Idle bus from time zero
    initial begin
        haddr_o = 32'h0000_0000;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hwdata_o = 32'h0000_0000;
    end

    // One single word transfer; caller enters just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        haddr_o <= a;
        htrans_o <= 2'h2;
        hwrite_o <= w;
        // Stale write data is inverted so no old value passes for new
        hwdata_o <= ~hwdata_o;
        // Hold address phase until hready is seen high
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'h0;
        hwdata_o <= d;
        // Hold data phase; read data taken at the same edge
        do @(posedge clk_i); while (hready_i !== 1'b1);
        q = hrdata_i;
    endtask : xfer
endmodule : sfdpr_host

`default_nettype wire

// ==== test/sfdp_basic_param_rom_tb_top.sv ====
// Self-checking bench for the parameter ROM slave.
// Assumes the slave's hreadyout loops back as the bus hready.
`timescale 1ns/100ps
`default_nettype none

module sfdp_basic_param_rom_tb_top;
    logic clk; // 125 MHz bus clock
    logic rst_n; // Active low reset
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic hwrite, hready, hresp;
    int errors, compares;
    // Expected table bytes 0x340 up, 128 Mb density
    logic [7:0] tbl [12] = '{8'hE5, 8'h20, 8'hFB, 8'hFF, 8'hFF, 8'hFF,
                             8'hFF, 8'h07, 8'h48, 8'hEB, 8'h08, 8'h6B};

    sfdpr_rom sfdpr_rom_i (.CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(1'b1),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp));
    sfdpr_host sfdpr_host_i (.clk_i(clk), .hready_i(hready),
        .hrdata_i(hrdata), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hwdata_o(hwdata));

    // Free running clock
    always #4 clk = ~clk;

    // Compare and count
    task automatic check(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // Register write and read through the bus model
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        sfdpr_host_i.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        sfdpr_host_i.xfer(1'b0, a, 32'h0000_0000, q);
        check("hresp", {31'h0, hresp}, 32'h0000_0000);
    endtask : rd

    // Pointer and density select come up cleared
    task automatic t_reset;
        logic [31:0] q;
        rd(32'h0000_0000, q);
        check("ptr reset", q, 32'h0000_0000);
        rd(32'h0000_0008, q);
        check("ctrl reset", q, 32'h0000_0000);
    endtask : t_reset

    // Second header pointer bytes stream in single reads, an idle cycle apart
    task automatic t_header;
        logic [31:0] q;
        logic [7:0] e [4] = '{8'h40, 8'h03, 8'h00, 8'hFF};
        wr(32'h0000_0000, 32'h0000_0014);
        for (int i = 0; i < 4; i++) begin
            rd(32'h0000_0004, q);
            check("header byte", q, {24'h0, e[i]});
        end
        rd(32'h0000_0000, q);
        check("ptr advanced", q, 32'h0000_0018);
    endtask : t_header

    // Whole visible basic table in one stream
    task automatic t_table;
        logic [31:0] q;
        wr(32'h0000_0000, 32'h0000_0340);
        for (int i = 0; i < 4; i++) begin
            rd(32'h0000_0004, q);
            check("tbl", q, {24'h0, tbl[i]});
        end
        for (int i = 4; i < 8; i++) begin
            rd(32'h0000_0004, q);
            check("tbl", q, {24'h0, tbl[i]});
        end
        for (int i = 8; i < 12; i++) begin
            rd(32'h0000_0004, q);
            check("tbl", q, {24'h0, tbl[i]});
        end
        // Past the visible table the erased fill comes back
        rd(32'h0000_0004, q);
        check("fill", q, 32'h0000_00FF);
    endtask : t_table

    // Larger density, ignored data write, unmapped place
    task automatic t_dens;
        logic [31:0] q;
        wr(32'h0000_0008, 32'h0000_0001);
        rd(32'h0000_0008, q);
        check("ctrl", q, 32'h0000_0001);
        wr(32'h0000_0000, 32'h0000_0347);
        rd(32'h0000_0004, q);
        check("density top", q, 32'h0000_000F);
        wr(32'h0000_0004, 32'h0000_00AA);
        rd(32'h0000_0000, q);
        check("ptr after data write", q, 32'h0000_0348);
        rd(32'h0000_0010, q);
        check("unmapped", q, 32'h0000_0000);
    endtask : t_dens

    // Verdict, reached by the sequence or the watchdog
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // Main sequence after a two cycle reset
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        errors = 0;
        compares = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_header;
        t_table;
        t_dens;
        print_verdict;
    end

    // Whole run needs well under a hundred transfers
    initial begin
        repeat (2000) @(posedge clk);
        errors++;
        print_verdict;
    end
endmodule : sfdp_basic_param_rom_tb_top

`default_nettype wire
